// *** rtl/bta_pkg.sv ***
// Package with constants and carrier types for the branch target address unit.
package bta_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0040;
  localparam logic [15:0] VEC_LAST = 16'h007f;
  localparam int unsigned VIDX_LSB = 1;
  localparam int unsigned VIDX_MSB = 5;
  localparam int unsigned DISP_SIGN = 7;
  localparam logic [2:0] LEN_MAX = 3'h4;
  localparam logic [15:0] BYTE_STEP = 16'h0001;

  typedef enum logic [2:0] {
    BTA_OP_SEQ,
    BTA_OP_REL,
    BTA_OP_ABS,
    BTA_OP_VEC,
    BTA_OP_REG,
    BTA_OP_DIR
  } bta_op_t;

  typedef struct packed {
    logic        valid;
    bta_op_t     op;
    logic [2:0]  len;
    logic        cond;
    logic [7:0]  disp;
    logic [15:0] imm;
    logic [15:0] pair;
  } bta_req_t;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } bta_mem_t;

endpackage

// *** rtl/bta_rel_add.sv ***
// Sign-extending adder for relative branch targets.
`timescale 1ns/1ns
module bta_rel_add
  import bta_pkg::*;
(
  input  wire logic [15:0] base,
  input  wire logic [7:0]  disp,
  output logic      [15:0] target
);
  logic [15:0] dispExt;

  always_comb begin
    dispExt = {{8{disp[DISP_SIGN]}}, disp};
    target  = base + dispExt;
  end
endmodule

// *** rtl/bta_unit.sv ***
// Program counter update and branch target generation unit.
`timescale 1ns/1ns
module bta_unit
  import bta_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire bta_req_t   req,
  input  wire logic [7:0] memData,
  output logic            busy,
  output logic            done,
  output logic [15:0]     instrPointer,
  output bta_mem_t        vecRead,
  output bta_mem_t        operandRead
);

  typedef enum logic [1:0] {
    BTA_IDLE,
    BTA_VLO,
    BTA_VHI
  } bta_state_t;

  typedef struct packed {
    bta_state_t  state;
    logic [15:0] ip;
    logic [7:0]  lowByte;
    logic        busy;
    logic        done;
    bta_mem_t    vec;
    bta_mem_t    opnd;
  } bta_regs_t;

  bta_regs_t   r;
  bta_regs_t   next_r;
  logic [15:0] nextSeq;
  logic [15:0] relTarget;
  logic [15:0] vecAddr;

  // Only a 16-bit pointer is served; other widths are refused at elaboration.
  if (ADDR_W != 16) begin : gen_addr_check
    $error("bta_unit supports only a 16-bit address space.");
  end

  bta_rel_add relAdd (
    .base   (nextSeq),
    .disp   (req.disp),
    .target (relTarget)
  );

  always_comb begin
    // The following instruction's address is both the fall-through and the relative base.
    nextSeq = r.ip + {13'h0000, req.len};
    vecAddr = VEC_BASE | {10'h000, req.imm[VIDX_MSB:VIDX_LSB], 1'b0};
    next_r = r;
    next_r.done = 1'b0;
    next_r.vec.rd = 1'b0;
    next_r.opnd.rd = 1'b0;
    case (r.state)
      BTA_IDLE: begin
        if (req.valid) begin
          next_r.done = 1'b1;
          case (req.op)
            BTA_OP_SEQ: begin
              next_r.ip = nextSeq;
            end
            BTA_OP_REL: begin
              next_r.ip = req.cond ? relTarget : nextSeq;
            end
            BTA_OP_ABS: begin
              next_r.ip = req.imm;
            end
            BTA_OP_VEC: begin
              // Further requests are ignored until both table bytes are in.
              next_r.done = 1'b0;
              next_r.busy = 1'b1;
              next_r.vec.rd = 1'b1;
              next_r.vec.addr = vecAddr;
              next_r.state = BTA_VLO;
            end
            BTA_OP_REG: begin
              next_r.ip = req.pair;
            end
            BTA_OP_DIR: begin
              next_r.opnd.rd = 1'b1;
              next_r.opnd.addr = req.imm;
              next_r.ip = nextSeq;
            end
            default: begin
              next_r.ip = nextSeq;
            end
          endcase
        end
      end
      BTA_VLO: begin
        // The low byte arrives while the odd-address read is being issued.
        next_r.lowByte = memData;
        next_r.vec.rd = 1'b1;
        next_r.vec.addr = r.vec.addr + BYTE_STEP;
        next_r.state = BTA_VHI;
      end
      BTA_VHI: begin
        // Both halves are in hand, so the entry becomes the new pointer.
        next_r.ip = {memData, r.lowByte};
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.state = BTA_IDLE;
      end
      default: begin
        next_r.state = BTA_IDLE;
        next_r.busy = 1'b0;
      end
    endcase
  end

  // Reset returns the pointer to its start address and drops every strobe.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      r <= '{state: BTA_IDLE, ip: IP_RESET, lowByte: 8'h00, busy: 1'b0, done: 1'b0,
             vec: '{rd: 1'b0, addr: 16'h0000}, opnd: '{rd: 1'b0, addr: 16'h0000}};
    end else begin
      r <= next_r;
    end
  end

  // Every output is a field of the state register.
  assign busy = r.busy;
  assign done = r.done;
  assign instrPointer = r.ip;
  assign vecRead = r.vec;
  assign operandRead = r.opnd;

  sequence seqIdleReq(bta_op_t o);
    r.state == BTA_IDLE && req.valid && req.op == o;
  endsequence

  // Low byte of the entry comes from the even address, the high byte from the next one.
  sequence seqVecLow;
    vecRead.rd && !vecRead.addr[0];
  endsequence

  sequence seqVecHigh;
    vecRead.rd && vecRead.addr == $past(vecRead.addr) + 16'h0001;
  endsequence

  AST_SEQ_ADVANCE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_SEQ) |=> instrPointer == $past(instrPointer) + {13'h0000, $past(req.len)})
    else $error("Pointer did not advance by instruction length.");

  AST_REL_TAKEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_REL) ##0 req.cond |=> instrPointer == $past(instrPointer)
      + {13'h0000, $past(req.len)} + {{8{$past(req.disp[7])}}, $past(req.disp)})
    else $error("Relative target wrong.");

  AST_REL_SIGN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_REL) ##0 req.cond && req.disp[7] && instrPointer > 16'h00ff
      && instrPointer < 16'hff00
      |=> instrPointer < $past(instrPointer) + {13'h0000, $past(req.len)})
    else $error("Negative displacement did not move backward.");

  AST_REL_NOTTAKEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_REL) ##0 !req.cond |=> instrPointer == $past(instrPointer)
      + {13'h0000, $past(req.len)})
    else $error("Untaken branch did not fall through.");

  AST_ABS_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_ABS) |=> instrPointer == $past(req.imm) && done)
    else $error("Absolute target not loaded.");

  AST_VEC_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    vecRead.rd |-> vecRead.addr >= VEC_BASE && vecRead.addr <= VEC_LAST)
    else $error("Vector read outside table.");

  AST_VEC_PAIR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_VEC) |=> seqVecLow ##1 seqVecHigh ##1 done
      && instrPointer == {$past(memData), $past(memData, 2)})
    else $error("Vector entry fetch sequence wrong.");

  AST_REG_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_REG) |=> instrPointer == $past(req.pair))
    else $error("Pair not copied into pointer.");

  AST_DIR_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_DIR) |=> operandRead.rd && operandRead.addr == $past(req.imm))
    else $error("Direct operand address wrong.");

  AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    r.state == BTA_IDLE && !req.valid |=> instrPointer == $past(instrPointer))
    else $error("Pointer moved without an executed instruction.");

  AST_DIR_ADVANCE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_DIR) |=> instrPointer == $past(instrPointer) + {13'h0000, $past(req.len)}
      && done)
    else $error("Direct operand instruction did not advance the pointer.");

  AST_BUSY_SPAN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqIdleReq(BTA_OP_VEC) |=> busy [*2] ##1 !busy && done)
    else $error("Vector fetch busy window wrong.");

  // A request offered in the middle of a table fetch must leave the pointer alone.
  AST_VEC_REFUSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    r.state == BTA_VLO && req.valid |=> instrPointer == $past(instrPointer) && r.state == BTA_VHI)
    else $error("Request accepted during a vector fetch.");

  AST_BUSY_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    busy |-> !operandRead.rd)
    else $error("Operand read issued during a vector fetch.");

  // Reset is checked without a disable so that the cleared state itself is observed.
  AST_RESET_CLEAR: assert property (@(posedge ref_clk)
    !rst_b |=> instrPointer == IP_RESET && !busy && !done && !vecRead.rd && !operandRead.rd)
    else $error("Reset did not clear the unit.");

endmodule

// *** tb/bta_mem_model.sv ***
// Program memory model that serves vector table bytes to the unit.
`timescale 1ns/1ns
module bta_mem_model
  import bta_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire bta_mem_t vecRead,
  output logic [7:0]    memData
);
  logic [7:0] idlePat = 8'h5a;

  // Outside a read the line changes every cycle so stale data is never mistaken for good.
  always @(posedge ref_clk) begin
    idlePat <= ~idlePat;
  end

  // A table byte holds its own address plus 31h.
  assign memData = vecRead.rd ? vecRead.addr[7:0] + 8'h31 : idlePat;
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the branch target address unit.
`timescale 1ns/1ns
module tb_top
  import bta_pkg::*;
;
  typedef struct packed {
    bta_op_t     op;
    logic [2:0]  len;
    logic        cond;
    logic [7:0]  disp;
    logic [15:0] imm;
    logic [15:0] pair;
    logic [15:0] ip;
    logic [15:0] adr;
    logic [1:0]  lat;
  } bta_row_t;

  logic        ref_clk = 1'b0;
  logic        rst_b   = 1'b0;
  bta_req_t    req     = '0;
  logic [7:0]  memData;
  logic        busy;
  logic        done;
  logic [15:0] instrPointer;
  bta_mem_t    vecRead;
  bta_mem_t    operandRead;
  logic [15:0] seenAdr;
  int          fails = 0;
  int          checks = 0;
  int          n;
  bta_row_t    rows [11];

  always #10 ref_clk = ~ref_clk;

  bta_unit dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .memData(memData), .busy(busy),
    .done(done), .instrPointer(instrPointer), .vecRead(vecRead), .operandRead(operandRead));

  bta_mem_model mem_u (.ref_clk(ref_clk), .vecRead(vecRead), .memData(memData));

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A clashing request is offered while a vector fetch is busy and must be ignored.
  task automatic issue(input bta_row_t r, input bit clash);
    @(posedge ref_clk);
    req <= '{1'b1, r.op, r.len, r.cond, r.disp, r.imm, r.pair};
    @(posedge ref_clk);
    req <= clash ? '{1'b1, BTA_OP_ABS, 3'h3, 1'b0, 8'h00, 16'hdead, 16'h0000} : '0;
    n = 1;
    seenAdr = 16'h0000;
    forever begin
      #1;
      if (n == 1) cmp16("busy", {15'h0, r.op == BTA_OP_VEC}, {15'h0, busy});
      if (vecRead.rd === 1'b1 && seenAdr === 16'h0000) seenAdr = vecRead.addr;
      if (operandRead.rd === 1'b1) seenAdr = operandRead.addr;
      if (done === 1'b1 || n == 8) break;
      @(posedge ref_clk);
      req.valid <= 1'b0;
      n++;
    end
    cmp16("instrPointer", r.ip, instrPointer);
    cmp16("latency", {14'h0, r.lat}, n[15:0]);
    if (r.op == BTA_OP_VEC || r.op == BTA_OP_DIR) begin
      cmp16("address", r.adr, seenAdr);
    end
  endtask

  initial begin
    rows = '{
      '{BTA_OP_SEQ, 3'h1, 1'b0, 8'h00, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 2'h1},
      '{BTA_OP_SEQ, 3'h3, 1'b0, 8'h00, 16'h0000, 16'h0000, 16'h0004, 16'h0000, 2'h1},
      '{BTA_OP_REL, 3'h2, 1'b1, 8'h7f, 16'h0000, 16'h0000, 16'h0085, 16'h0000, 2'h1},
      '{BTA_OP_REL, 3'h2, 1'b1, 8'h80, 16'h0000, 16'h0000, 16'h0007, 16'h0000, 2'h1},
      '{BTA_OP_REL, 3'h2, 1'b0, 8'h10, 16'h0000, 16'h0000, 16'h0009, 16'h0000, 2'h1},
      '{BTA_OP_ABS, 3'h3, 1'b0, 8'h00, 16'h1234, 16'h0000, 16'h1234, 16'h0000, 2'h1},
      '{BTA_OP_REL, 3'h2, 1'b1, 8'hf0, 16'h0000, 16'h0000, 16'h1226, 16'h0000, 2'h1},
      '{BTA_OP_REG, 3'h1, 1'b0, 8'h00, 16'h0000, 16'habcd, 16'habcd, 16'h0000, 2'h1},
      '{BTA_OP_DIR, 3'h3, 1'b0, 8'h00, 16'h5678, 16'h0000, 16'habd0, 16'h5678, 2'h1},
      '{BTA_OP_VEC, 3'h1, 1'b0, 8'h00, 16'h003e, 16'h0000, 16'hb0af, 16'h007e, 2'h3},
      '{BTA_OP_VEC, 3'h1, 1'b0, 8'h00, 16'h0001, 16'h0000, 16'h7271, 16'h0040, 2'h3}};
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    cmp16("instrPointer", IP_RESET, instrPointer);
    for (int i = 0; i < 11; i++) begin
      issue(rows[i], 1'b0);
    end
    issue('{BTA_OP_VEC, 3'h1, 1'b0, 8'h00, 16'h0002, 16'h0, 16'h7473, 16'h0042, 2'h3},
          1'b1);
    // Reset lands in the middle of a vector fetch and must abandon it.
    @(posedge ref_clk);
    req <= '{1'b1, BTA_OP_VEC, 3'h1, 1'b0, 8'h00, 16'h0004, 16'h0000};
    @(posedge ref_clk);
    req <= '0;
    rst_b <= 1'b0;
    @(posedge ref_clk);
    #1;
    cmp16("instrPointer", IP_RESET, instrPointer);
    cmp16("done", 16'h0000, {15'h0, done});
    cmp16("busy", 16'h0000, {15'h0, busy});
    cmp16("vecRead.rd", 16'h0000, {15'h0, vecRead.rd});
    @(posedge ref_clk);
    rst_b <= 1'b1;
    issue('{BTA_OP_SEQ, 3'h2, 1'b0, 8'h00, 16'h0, 16'h0, 16'h0002, 16'h0, 2'h1},
          1'b0);
    test_done();
  end

  initial begin
    repeat (400) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule
